// ===== hdl/pcs_pkg.sv
// Shared constants and types of the bus target signalling block.
// Assumes a 32-bit multiplexed address/data bus clocked at 200 MHz.
package pcs_pkg;

  // ****************************************
  // Main sequencer states
  // ****************************************
  typedef enum logic [3:0] {
    PCS_IDLE  = 4'h1,
    PCS_DATA  = 4'h2,
    PCS_RETRY = 4'h4,
    PCS_TURN  = 4'h8
  } pcs_state_t;

  // ****************************************
  // Bus commands and field positions
  // ****************************************
  localparam logic [3:0] PCS_CMD_CFG_RD = 4'hA;
  localparam logic [3:0] PCS_CMD_CFG_WR = 4'hB;
  localparam int         PCS_CMD_WR_BIT = 0;
  localparam logic [1:0] PCS_CFG_TYPE0  = 2'h0;
  localparam int         PCS_AD_W       = 32;
  localparam int         PCS_BE_W       = 4;

  // ****************************************
  // Pin driver slots and reset values
  // ****************************************
  localparam int PCS_TRDY   = 0;
  localparam int PCS_STOP   = 1;
  localparam int PCS_DEVSEL = 2;
  localparam int PCS_PERR   = 3;
  localparam int PCS_SERR   = 4;
  localparam int PCS_INTA   = 5;
  localparam int PCS_INTB   = 6;
  localparam int PCS_NSTS   = 4;
  localparam int PCS_NSIG   = 7;
  localparam logic [31:0] PCS_AD_RST = 32'h0000_0000;
  localparam logic [3:0]  PCS_BE_RST = 4'h0;

endpackage

// ===== hdl/pcs_sts_if.sv
// Carrier between the sequencer and one low-active pin driver.
// Assumes the driver registers what the sequencer asks for.
`timescale 1ns/1ps
interface pcs_sts_if;
  logic active;
  logic own;
  logic pin_n;
  logic pin_oe;
  modport ctl (output active, output own, input pin_n, input pin_oe);
  modport drv (input active, input own, output pin_n, output pin_oe);
endinterface

// ===== hdl/pcs_sts_drv.sv
// Registered driver for one low-active shared pin.
// Assumes an external pull-up holds the pin high while it floats.
`timescale 1ns/1ps
module pcs_sts_drv
  import pcs_pkg::*;
#(
  parameter bit HOLD_HIGH = 1'b1
) (
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  pcs_sts_if.drv    bus
);

  typedef struct packed {
    logic pin_n;
    logic pin_oe;
    logic hi;
  } pcs_drv_t;

  pcs_drv_t s;
  pcs_drv_t next_s;

  // ****************************************
  // Next pin state
  // ****************************************
  // Sustained pins drive high one clock after ownership ends, then float
  always_comb begin
    next_s.pin_n  = !bus.active;
    next_s.hi     = HOLD_HIGH && s.pin_oe && !s.hi && !bus.own && !bus.active;
    next_s.pin_oe = bus.active || bus.own || next_s.hi;
  end

  // Floats and releases the pin while reset is held
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '{pin_n: 1'b1, pin_oe: 1'b0, hi: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign bus.pin_n  = s.pin_n;
  assign bus.pin_oe = s.pin_oe;

  AST_HIGH_BEFORE_FLOAT: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    HOLD_HIGH && $fell(s.pin_oe) |-> $past(s.pin_n))
    else $error("sustained pin floated without driving high");

  AST_OPEN_DRAIN_LOW: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !HOLD_HIGH && s.pin_oe |-> !s.pin_n)
    else $error("open-drain pin driven high");

endmodule

// ===== hdl/pcs_parity.sv
// Even parity generator and one-clock-late checker.
// Assumes the parity bit for a bus state arrives one clock after it.
`timescale 1ns/1ps
module pcs_parity
  import pcs_pkg::*;
#(
  parameter int W = PCS_AD_W + PCS_BE_W
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_check,
  input  wire logic         i_par,
  output wire logic         o_par,
  output wire logic         o_err
);

  typedef struct packed {
    logic par;
    logic chk;
  } pcs_par_t;

  pcs_par_t s;
  pcs_par_t next_s;

  // ****************************************
  // Parity of the previous bus state
  // ****************************************
  always_comb begin
    next_s.par = ^i_data;
    next_s.chk = i_check;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '{par: 1'b0, chk: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // Incoming parity compared with the locally computed bit
  assign o_par = s.par;
  assign o_err = s.chk && (i_par != s.par);

endmodule

// ===== hdl/pcs_target.sv
// Target-side signalling of a 32-bit multiplexed bus slave.
// Assumes a single initiator-side clock; inputs are synchronous to it,
// and the back end decodes addresses and supplies data on the user ports.
//
// Notes on behaviour
// - A data phase completes on each edge where initiator and target ready are both low.
// - The target asks the master to stop, the meaning set by target ready and device select.
// - Lock is taken when the lock input is seen high in a claimed address phase.
// - While locked, accesses from any other master end in a retry.
// - A type-0 configuration cycle with chip select high is claimed on the next clock.
// - Other cycles are claimed only on a positive address decode.
// - Even parity over address/data and command lines is driven in read data phases.
// - Parity is checked in claimed address phases and in completed write data phases.
// - Parity drive starts and stops one clock after address/data drive.
// - Card-socket interrupts go out on request line A, gated by routing bit 0.
// - Disk interrupts go out on request line B, gated by routing bit 1.
// - Data parity errors are reported on the sustained parity error pin.
// - Address parity errors pull the system error pin low for exactly one clock.
// - A sustained pin is driven high for one clock before it floats.
// - All bus signals are sampled on the rising clock edge.
// - Reset floats every output, releases open-drain pins and clears all state.
`timescale 1ns/1ps
module pcs_target
  import pcs_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic [31:0] i_ad,
  output wire logic [31:0] o_ad,
  output wire logic        o_ad_oe,
  input  wire logic [3:0]  i_cbe_n,
  input  wire logic        i_frame_n,
  input  wire logic        i_irdy_n,
  input  wire logic        i_idsel,
  input  wire logic        i_bus_lock_input_n,
  input  wire logic        i_par,
  output wire logic        o_par,
  output wire logic        o_par_oe,
  output wire logic        o_trdy_n,
  output wire logic        o_trdy_oe,
  output wire logic        o_stop_n,
  output wire logic        o_stop_oe,
  output wire logic        o_devsel_n,
  output wire logic        o_devsel_oe,
  output wire logic        o_perr_n,
  output wire logic        o_perr_oe,
  output wire logic        o_serr_n,
  output wire logic        o_serr_oe,
  output wire logic        o_inta_n,
  output wire logic        o_inta_oe,
  output wire logic        o_intb_n,
  output wire logic        o_intb_oe,
  input  wire logic        i_dec_hit,
  input  wire logic        i_data_ready,
  input  wire logic [31:0] i_rd_data,
  output wire logic [31:0] o_addr,
  output wire logic [3:0]  o_cmd,
  output wire logic        o_cfg_sel,
  output wire logic        o_wr_strobe,
  output wire logic [31:0] o_wr_data,
  output wire logic [3:0]  o_wr_be,
  output wire logic        o_rd_ack,
  output wire logic        o_locked,
  input  wire logic        i_card_irq,
  input  wire logic        i_disk_irq,
  input  wire logic [1:0]  i_interrupt_request_routing_register
);

  // ****************************************
  // State record
  // ****************************************
  typedef struct packed {
    pcs_state_t  st;
    logic        frame_q;
    logic        rd;
    logic        locked;
    logic        chk_addr;
    logic        chk_wr;
    logic [31:0] ad;
    logic        ad_oe;
    logic        par_oe;
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic        cfg;
    logic        wr_stb;
    logic        rd_ack;
    logic [31:0] wr_data;
    logic [3:0]  wr_be;
  } pcs_top_t;

  localparam pcs_top_t PCS_TOP_RST = '{
    st: PCS_IDLE, frame_q: 1'b1, ad: PCS_AD_RST, addr: PCS_AD_RST,
    wr_data: PCS_AD_RST, cmd: PCS_BE_RST, wr_be: PCS_BE_RST, default: 1'b0
  };

  pcs_top_t s;
  pcs_top_t next_s;

  pcs_sts_if sif [PCS_NSIG] ();

  logic addr_ph;
  logic is_cfg;
  logic claim;
  logic other;
  logic trdy_on;
  logic stop_on;
  logic devsel_on;
  logic done;
  logic last;
  logic hold;
  logic trdy_act;
  logic own;
  logic par_err;
  logic par_bus;

  // ****************************************
  // Bus decode
  // ****************************************
  // Address phase is the first low clock of the frame while idle
  assign addr_ph   = (s.st == PCS_IDLE) && s.frame_q && !i_frame_n;
  assign is_cfg    = ((i_cbe_n == PCS_CMD_CFG_RD) || (i_cbe_n == PCS_CMD_CFG_WR))
                     && i_idsel && (i_ad[1:0] == PCS_CFG_TYPE0);
  assign claim     = addr_ph && (is_cfg || i_dec_hit);
  assign other     = s.locked && !i_bus_lock_input_n;
  assign trdy_on   = sif[PCS_TRDY].pin_oe && !sif[PCS_TRDY].pin_n;
  assign stop_on   = sif[PCS_STOP].pin_oe && !sif[PCS_STOP].pin_n;
  assign devsel_on = sif[PCS_DEVSEL].pin_oe && !sif[PCS_DEVSEL].pin_n;
  assign done      = trdy_on && !i_irdy_n;
  assign last      = done && i_frame_n;
  assign hold      = trdy_on && !done;
  assign par_bus   = ^{i_ad, i_cbe_n};

  // ****************************************
  // Sequencer
  // ****************************************
  // Decides claim, data handshake, retry and release of the bus
  always_comb begin
    next_s          = s;
    trdy_act        = 1'b0;
    next_s.frame_q  = i_frame_n;
    next_s.par_oe   = s.ad_oe;
    next_s.wr_stb   = done && !s.rd;
    next_s.rd_ack   = done && s.rd;
    next_s.chk_addr = claim;
    next_s.chk_wr   = done && !s.rd;
    if (done && !s.rd) begin
      next_s.wr_data = i_ad;
      next_s.wr_be   = ~i_cbe_n;
    end
    // Lock is taken with the input high in a claimed address phase and dropped with the input and frame both high
    if (claim && i_bus_lock_input_n) begin
      next_s.locked = 1'b1;
    end else if (i_bus_lock_input_n && i_frame_n) begin
      next_s.locked = 1'b0;
    end
    case (s.st)
      PCS_IDLE: begin
        next_s.ad_oe = 1'b0;
        if (claim) begin
          next_s.st   = other ? PCS_RETRY : PCS_DATA;
          next_s.rd   = !i_cbe_n[PCS_CMD_WR_BIT];
          next_s.addr = i_ad;
          next_s.cmd  = i_cbe_n;
          next_s.cfg  = is_cfg;
        end
      end
      PCS_DATA: begin
        if (last) begin
          next_s.st = PCS_TURN;
        end
        // Read data waits one clock for the address turnaround
        next_s.ad_oe = s.rd && !last;
        if (!hold) begin
          next_s.ad = i_rd_data;
        end
        trdy_act = hold || (!last && i_data_ready && (!s.rd || s.ad_oe));
      end
      PCS_RETRY: begin
        if (i_frame_n) begin
          next_s.st = PCS_TURN;
        end
      end
      PCS_TURN: begin
        next_s.ad_oe = 1'b0;
        next_s.st    = PCS_IDLE;
      end
      default: begin
        next_s = PCS_TOP_RST;
      end
    endcase
  end

  // Registers all state on the rising edge of the bus clock
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= PCS_TOP_RST;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  // Device select and stop follow ownership of the transaction
  assign own = (next_s.st == PCS_DATA) || (next_s.st == PCS_RETRY);
  assign sif[PCS_TRDY].active   = trdy_act;
  assign sif[PCS_TRDY].own      = own;
  assign sif[PCS_STOP].active   = next_s.st == PCS_RETRY;
  assign sif[PCS_STOP].own      = own;
  assign sif[PCS_DEVSEL].active = own;
  assign sif[PCS_DEVSEL].own    = own;
  assign sif[PCS_PERR].active   = par_err && s.chk_wr;
  assign sif[PCS_PERR].own      = 1'b0;
  assign sif[PCS_SERR].active   = par_err && s.chk_addr;
  assign sif[PCS_SERR].own      = 1'b0;
  assign sif[PCS_INTA].active   = i_card_irq && i_interrupt_request_routing_register[0];
  assign sif[PCS_INTA].own      = 1'b0;
  assign sif[PCS_INTB].active   = i_disk_irq && i_interrupt_request_routing_register[1];
  assign sif[PCS_INTB].own      = 1'b0;

  // Sustained pins hold high before floating, open-drain ones do not
  for (genvar g = 0; g < PCS_NSIG; g++) begin : g_drv
    pcs_sts_drv #(
      .HOLD_HIGH (g < PCS_NSTS)
    ) u_drv (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .bus       (sif[g])
    );
  end

  // Parity over the bus lines, checked one clock after the phase
  pcs_parity #(
    .W (PCS_AD_W + PCS_BE_W)
  ) u_par (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_data    ({i_ad, i_cbe_n}),
    .i_check   (claim || (done && !s.rd)),
    .i_par     (i_par),
    .o_par     (o_par),
    .o_err     (par_err)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign o_ad        = s.ad;
  assign o_ad_oe     = s.ad_oe;
  assign o_par_oe    = s.par_oe;
  assign o_trdy_n    = sif[PCS_TRDY].pin_n;
  assign o_trdy_oe   = sif[PCS_TRDY].pin_oe;
  assign o_stop_n    = sif[PCS_STOP].pin_n;
  assign o_stop_oe   = sif[PCS_STOP].pin_oe;
  assign o_devsel_n  = sif[PCS_DEVSEL].pin_n;
  assign o_devsel_oe = sif[PCS_DEVSEL].pin_oe;
  assign o_perr_n    = sif[PCS_PERR].pin_n;
  assign o_perr_oe   = sif[PCS_PERR].pin_oe;
  assign o_serr_n    = sif[PCS_SERR].pin_n;
  assign o_serr_oe   = sif[PCS_SERR].pin_oe;
  assign o_inta_n    = sif[PCS_INTA].pin_n;
  assign o_inta_oe   = sif[PCS_INTA].pin_oe;
  assign o_intb_n    = sif[PCS_INTB].pin_n;
  assign o_intb_oe   = sif[PCS_INTB].pin_oe;
  assign o_addr      = s.addr;
  assign o_cmd       = s.cmd;
  assign o_cfg_sel   = s.cfg;
  assign o_wr_strobe = s.wr_stb;
  assign o_wr_data   = s.wr_data;
  assign o_wr_be     = s.wr_be;
  assign o_rd_ack    = s.rd_ack;
  assign o_locked    = s.locked;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_cfg_hit;
    addr_ph && is_cfg;
  endsequence

  sequence s_addr_bad;
    claim ##1 (i_par != $past(par_bus));
  endsequence

  sequence s_wr_bad;
    (done && !s.rd) ##1 (i_par != $past(par_bus));
  endsequence

  AST_CFG_CLAIM: assert property (s_cfg_hit |=> devsel_on)
    else $error("configuration cycle not claimed");

  AST_NO_DECODE: assert property (
    addr_ph && !is_cfg && !i_dec_hit |=> !devsel_on)
    else $error("cycle claimed without decode");

  AST_TRDY_HOLD: assert property (trdy_on && i_irdy_n |=> trdy_on)
    else $error("target ready dropped before completion");

  AST_PAR_LAG: assert property (o_par_oe == $past(o_ad_oe))
    else $error("parity drive not one clock behind data");

  AST_PAR_VALUE: assert property (o_par_oe |-> o_par == $past(par_bus))
    else $error("driven parity not even");

  AST_RETRY: assert property (
    claim && other |=> stop_on && devsel_on && !trdy_on ##1 (stop_on == devsel_on))
    else $error("locked access from other master not retried");

  AST_STOP_DEV: assert property (stop_on |-> devsel_on)
    else $error("stop without device select");

  AST_SERR_PULSE: assert property (o_serr_oe |-> !o_serr_n ##1 !o_serr_oe)
    else $error("system error not a single clock");

  AST_SERR_CAUSE: assert property (s_addr_bad |=> o_serr_oe)
    else $error("address parity error not reported");

  AST_PERR_CAUSE: assert property (s_wr_bad |=> o_perr_oe && !o_perr_n)
    else $error("data parity error not reported");

  AST_INTA: assert property (
    o_inta_oe == $past(i_card_irq && i_interrupt_request_routing_register[0]))
    else $error("request A does not follow card interrupt");

  AST_INTB: assert property (
    o_intb_oe == $past(i_disk_irq && i_interrupt_request_routing_register[1]))
    else $error("request B does not follow disk interrupt");

  AST_LOCK_HOLD: assert property (
    s.locked && !(i_bus_lock_input_n && i_frame_n) |=> s.locked)
    else $error("lock lost while held");

  AST_RESET_FLOAT: assert property (
    $rose(i_resetn) |-> !o_ad_oe && !o_trdy_oe && !o_devsel_oe && !o_serr_oe)
    else $error("outputs driven at reset release");

endmodule

// ===== tb/pcs_initiator.sv
// Bus initiator model: one address phase and one data phase per transfer.
// Assumes the bench resolves the shared lines and feeds the wire levels back.
`timescale 1ns/1ps
module pcs_initiator
  import pcs_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic [31:0] i_ad,
  input  wire logic        i_par,
  input  wire logic        i_trdy_n,
  input  wire logic        i_stop_n,
  output logic [31:0]      o_ad,
  output logic             o_ad_oe,
  output logic [3:0]       o_cbe_n,
  output logic             o_frame_n,
  output logic             o_irdy_n,
  output logic             o_idsel,
  output logic             o_lock_n,
  output logic             o_par,
  output logic             o_par_oe
);
  logic rd_par;
  int   irdy_wait;

  // ****************************************
  // Idle bus
  // ****************************************
  initial begin
    o_ad = 32'h0000_0000;
    o_ad_oe = 1'b0;
    o_cbe_n = 4'hF;
    o_frame_n = 1'b1;
    o_irdy_n = 1'b1;
    o_idsel = 1'b0;
    o_lock_n = 1'b0;
    o_par = 1'b0;
    o_par_oe = 1'b0;
    rd_par = 1'b0;
    irdy_wait = 0;
  end

  // Sets the lock line between transfers
  task automatic hold_lock(input logic v);
    o_lock_n = v;
  endtask

  // ****************************************
  // One transfer; bad[0] spoils address parity, bad[1] data parity
  // ****************************************
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, wdata,
                      input logic sel, lk, input logic [1:0] bad,
                      output logic [31:0] rdata, output logic done, stopped);
    logic wr;
    wr = cmd[PCS_CMD_WR_BIT];
    done = 1'b0;
    stopped = 1'b0;
    rdata = 32'h0000_0000;
    @(negedge i_sys_clk);
    o_frame_n = 1'b0;
    o_ad = addr;
    o_ad_oe = 1'b1;
    o_cbe_n = cmd;
    o_idsel = sel;
    o_lock_n = lk;
    @(negedge i_sys_clk);
    o_par = ^{addr, cmd} ^ bad[0];
    o_par_oe = 1'b1;
    o_frame_n = 1'b1;
    o_irdy_n = (irdy_wait > 0);   // write data valid, or ready to take read data
    o_ad = wdata;
    o_ad_oe = wr;
    o_cbe_n = 4'h0;
    o_idsel = 1'b0;
    o_lock_n = 1'b0;
    // Bounded wait stands in for a master abort
    for (int n = 0; n < 8 && !done && !stopped; n++) begin
      @(posedge i_sys_clk);
      done = !i_trdy_n && !o_irdy_n;
      stopped = !i_stop_n;
      rdata = i_ad;
      // Initiator wait states: ready goes low after irdy_wait clocks
      if (n + 1 == irdy_wait && !stopped) begin
        @(negedge i_sys_clk);
        o_irdy_n = 1'b0;
      end
    end
    @(negedge i_sys_clk);
    o_irdy_n = 1'b1;
    o_ad_oe = 1'b0;
    o_par = ^{wdata, 4'h0} ^ bad[1];
    o_par_oe = wr;
    @(posedge i_sys_clk);
    rd_par = i_par;
    @(negedge i_sys_clk);
    o_par_oe = 1'b0;
  endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench of the bus target signalling block.
// Assumes pull-ups on every shared low-active line and a single bus clock.
`timescale 1ns/1ps
module tb;
  import pcs_pkg::*;
  logic        clk, rstn, rdy, card, disk, idsel, lock_n, frame_n, irdy_n;
  logic [1:0]  route;
  logic [3:0]  cbe_n, cmd, wr_be, prev_oe, prev_n, sus_oe, sus_n;
  logic [31:0] rd_word, cyc, ad_i, ad_t, addr, wr_data, bus_ad, rd;
  logic        ad_i_oe, par_i, par_i_oe, ad_t_oe, par_t, par_t_oe, bus_par, dec_hit, ok, st;
  logic        trdy_n, trdy_oe, stop_n, stop_oe, devsel_n, devsel_oe, perr_n, perr_oe;
  logic        serr_n, serr_oe, inta_n, inta_oe, intb_n, intb_oe, cfg_sel, wr_strobe, locked;
  logic        rd_ack;
  int          error_cnt, checked, srun, serr_cnt, perr_cnt, wr_cnt, rd_cnt;

  // ****************************************
  // Wire resolution; a floating AD shows a changing pattern
  // ****************************************
  assign bus_ad = ad_t_oe ? ad_t : ad_i_oe ? ad_i : {cyc[15:0], ~cyc[15:0]};
  assign bus_par = par_t_oe ? par_t : par_i_oe ? par_i : cyc[0];
  assign sus_oe = {trdy_oe, stop_oe, devsel_oe, perr_oe};
  assign sus_n = {trdy_n, stop_n, devsel_n, perr_n};
  assign dec_hit = (bus_ad[31:28] == 4'h8);

  pcs_initiator ini (
    .i_sys_clk(clk), .i_ad(bus_ad), .i_par(bus_par),
    .i_trdy_n(trdy_oe ? trdy_n : 1'b1), .i_stop_n(stop_oe ? stop_n : 1'b1),
    .o_ad(ad_i), .o_ad_oe(ad_i_oe), .o_cbe_n(cbe_n), .o_frame_n(frame_n), .o_irdy_n(irdy_n),
    .o_idsel(idsel), .o_lock_n(lock_n), .o_par(par_i), .o_par_oe(par_i_oe)
  );

  pcs_target DUT (
    .i_sys_clk(clk), .i_resetn(rstn), .i_ad(bus_ad), .o_ad(ad_t), .o_ad_oe(ad_t_oe),
    .i_cbe_n(cbe_n), .i_frame_n(frame_n), .i_irdy_n(irdy_n), .i_idsel(idsel),
    .i_bus_lock_input_n(lock_n), .i_par(bus_par), .o_par(par_t), .o_par_oe(par_t_oe),
    .o_trdy_n(trdy_n), .o_trdy_oe(trdy_oe), .o_stop_n(stop_n), .o_stop_oe(stop_oe),
    .o_devsel_n(devsel_n), .o_devsel_oe(devsel_oe), .o_perr_n(perr_n), .o_perr_oe(perr_oe),
    .o_serr_n(serr_n), .o_serr_oe(serr_oe), .o_inta_n(inta_n), .o_inta_oe(inta_oe),
    .o_intb_n(intb_n), .o_intb_oe(intb_oe), .i_dec_hit(dec_hit), .i_data_ready(rdy),
    .i_rd_data(rd_word), .o_addr(addr), .o_cmd(cmd), .o_cfg_sel(cfg_sel),
    .o_wr_strobe(wr_strobe), .o_wr_data(wr_data), .o_wr_be(wr_be), .o_rd_ack(rd_ack),
    .o_locked(locked), .i_card_irq(card), .i_disk_irq(disk),
    .i_interrupt_request_routing_register(route)
  );

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input logic [31:0] seen, exp, input string m);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic end_of_test;
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Clock and cycle ceiling
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 32'h0000_0001;
    if (cyc == 32'h0000_0FA0) begin
      error_cnt++;
      end_of_test();
    end
  end

  // Pin monitors: high drive before float, system error pulse width, error and strobe counts
  always @(posedge clk) begin
    if (rstn) begin
      for (int i = 0; i < 4; i++) begin
        if (prev_oe[i] && !sus_oe[i]) chk(prev_n[i], 1'b1, "float without high drive");
      end
      if (serr_oe) begin
        srun++;
        chk(serr_n, 1'b0, "system error level");
      end else if (srun != 0) begin
        chk(srun, 1, "system error width");
        serr_cnt++;
        srun = 0;
      end
      if (perr_oe && !perr_n) perr_cnt++;
      if (wr_strobe) wr_cnt++;
      if (rd_ack) rd_cnt++;
    end
    prev_oe = sus_oe;
    prev_n = sus_n;
  end

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_cfg;
    ini.xfer(PCS_CMD_CFG_WR, 32'h0000_0010, 32'hC0DE_1234, 1'b1, 1'b0, 2'h0, rd, ok, st);
    chk(ok, 1'b1, "config write claim");
    chk(wr_cnt, 1, "config write strobe");
    chk(wr_data, 32'hC0DE_1234, "write data");
    chk(wr_be, 4'hF, "write byte enables");
    chk({cfg_sel, cmd}, {1'b1, PCS_CMD_CFG_WR}, "config flag");
    chk(addr, 32'h0000_0010, "captured address");
    ini.xfer(PCS_CMD_CFG_RD, 32'h0000_0011, 32'h0, 1'b1, 1'b0, 2'h0, rd, ok, st);
    chk(ok, 1'b0, "low bits set claimed");
    ini.xfer(PCS_CMD_CFG_RD, 32'h0000_0014, 32'h0, 1'b0, 1'b0, 2'h0, rd, ok, st);
    chk(ok, 1'b0, "no chip select claimed");
    ini.xfer(PCS_CMD_CFG_RD, 32'h0000_0014, 32'h0, 1'b1, 1'b0, 2'h0, rd, ok, st);
    chk(ok, 1'b1, "config read claim");
    chk(rd, rd_word, "config read data");
    chk(ini.rd_par, ^{rd_word, 4'h0}, "read parity");
  endtask

  task automatic t_mem;
    ini.xfer(4'h7, 32'h8000_0100, 32'h0F1E_2D3C, 1'b0, 1'b0, 2'h0, rd, ok, st);
    chk(ok, 1'b1, "decoded write");
    chk(wr_data, 32'h0F1E_2D3C, "decoded write data");
    ini.xfer(4'h7, 32'h4000_0100, 32'h1111_2222, 1'b0, 1'b0, 2'h0, rd, ok, st);
    chk(ok, 1'b0, "undecoded write");
    chk(wr_cnt, 2, "undecoded write strobe");
    ini.xfer(4'h6, 32'h8000_0200, 32'h0, 1'b0, 1'b0, 2'h0, rd, ok, st);
    chk(ok, 1'b1, "decoded read");
    chk(rd, rd_word, "decoded read data");
    chk(rd_cnt, 2, "read acknowledges");
    chk(ini.rd_par, ^{rd_word, 4'h0}, "read parity");
  endtask

  task automatic t_parity;
    ini.xfer(4'h7, 32'h8000_0040, 32'h1357_9BDF, 1'b0, 1'b0, 2'h1, rd, ok, st);
    repeat (4) @(negedge clk);
    chk(serr_cnt, 1, "address parity error");
    chk(perr_cnt, 0, "no data parity error");
    ini.xfer(4'h7, 32'h8000_0044, 32'h1357_9BDF, 1'b0, 1'b0, 2'h2, rd, ok, st);
    repeat (4) @(negedge clk);
    chk(serr_cnt, 1, "no extra system error");
    chk(perr_cnt, 1, "data parity error");
    ini.xfer(4'h7, 32'h4000_0044, 32'h1357_9BDF, 1'b0, 1'b0, 2'h3, rd, ok, st);
    repeat (4) @(negedge clk);
    chk(serr_cnt, 1, "unclaimed address parity error");
    chk(perr_cnt, 1, "unclaimed data parity error");
  endtask

  task automatic t_lock;
    ini.xfer(4'h6, 32'h8000_0300, 32'h0, 1'b0, 1'b1, 2'h0, rd, ok, st);
    chk({ok, locked}, 2'h3, "lock taken");
    ini.xfer(4'h7, 32'h8000_0304, 32'h2222_3333, 1'b0, 1'b0, 2'h0, rd, ok, st);
    chk({st, ok}, 2'h2, "retry while locked");
    chk(wr_cnt, 4, "no write while locked");
    ini.hold_lock(1'b1);
    repeat (2) @(negedge clk);
    chk(locked, 1'b0, "lock released");
    ini.hold_lock(1'b0);
  endtask

  // Initiator wait states on a write, back end wait on a read
  task automatic t_wait;
    ini.irdy_wait = 2;
    ini.xfer(4'h7, 32'h8000_0104, 32'h3C2D_1E0F, 1'b0, 1'b0, 2'h0, rd, ok, st);
    ini.irdy_wait = 0;
    chk(ok, 1'b1, "write with initiator wait");
    chk(wr_data, 32'h3C2D_1E0F, "waited write");
    chk(wr_cnt, 5, "waited write strobe");
    rdy = 1'b0;
    fork
      ini.xfer(4'h6, 32'h8000_0108, 32'h0, 1'b0, 1'b0, 2'h0, rd, ok, st);
      begin
        repeat (4) @(negedge clk);
        rdy = 1'b1;
      end
    join
    chk(ok, 1'b1, "read after back end wait");
    chk(rd, rd_word, "waited read data");
    chk(rd_cnt, 4, "waited read acknowledge");
  endtask

  task automatic t_irq;
    for (int i = 0; i < 16; i++) begin
      route = i[1:0];
      card = i[2];
      disk = i[3];
      repeat (2) @(negedge clk);
      chk(inta_oe, i[0] & i[2], "request line A");
      chk(intb_oe, i[1] & i[3], "request line B");
      chk(inta_n, !(i[0] & i[2]), "level A");
      chk(intb_n, !(i[1] & i[3]), "level B");
    end
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    rdy = 1'b1;
    card = 1'b0;
    disk = 1'b0;
    route = 2'h0;
    rd_word = 32'h5A5A_C33C;
    cyc = 32'h0000_0000;
    repeat (20) @(negedge clk);
    chk({ad_t_oe, par_t_oe, sus_oe, serr_oe, inta_oe, intb_oe, locked}, 0, "reset idle");
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    t_cfg();
    t_mem();
    t_parity();
    t_lock();
    t_wait();
    t_irq();
    end_of_test();
  end
endmodule
